// ==== mdl_map.svh ====
/*
  constants for the multiply/divide/logic decoder slice.
  assumes a 25 MHz core clock; counts are in core clock cycles.
*/
// Operation
// - 1111011w reg 101 is signed multiply, 25-28/34-37/31-34/40-43 cycles
// - 011010s1 is immediate signed multiply; second immediate byte only when s=0
// - 1111011w reg 110 is unsigned divide, 29/38/35/44 cycles
// - 1111011w reg 111 is signed divide, 44-52/53-61/50-58/59-67 cycles
// - 11010100 00001010 is ascii multiply adjust, 19 cycles
// - 11010101 00001010 is ascii divide adjust, 15 cycles
// - 10011000 sign-extends low accumulator byte to word, 2 cycles
// - 10011001 sign-extends accumulator word to double word, 4 cycles
// - modrm bits 5:3 pick rotate/shift kind; 110 undefined
// - and forms 001000dw, 1000000w/100, 0010010w at 3/10, 4/16, 3/4
// - or forms 000010dw, 1000000w/001, 0000110w at 3/10, 4/16, 3/4
// - 1000010w tests register against operand, flags only, 3/10 cycles
// - 1111011w reg 000 with immediate tests, flags only, 4/10 cycles
// - 1010100w tests accumulator with immediate, 3/4; second byte when w=1
// - narrow bus: word operations add 4 cycles per memory transfer; the code adds 4 once, to starred word forms with a memory operand only
`ifndef MDL_MAP_SVH
`define MDL_MAP_SVH
`define MDL_CLK_MHZ        25
`define MDL_WORD_MEM_ADD   8'h04
`define MDL_SMUL_RB        8'h19
`define MDL_SMUL_RW        8'h22
`define MDL_SMUL_MB        8'h1f
`define MDL_SMUL_MW        8'h28
`define MDL_SMUL_SPAN      8'h03
`define MDL_IMMUL_R        8'h16
`define MDL_IMMUL_M        8'h1d
`define MDL_DIV_RB         8'h1d
`define MDL_DIV_RW         8'h26
`define MDL_DIV_MB         8'h23
`define MDL_DIV_MW         8'h2c
`define MDL_SDIV_RB        8'h2c
`define MDL_SDIV_RW        8'h35
`define MDL_SDIV_MB        8'h32
`define MDL_SDIV_MW        8'h3b
`define MDL_SDIV_SPAN      8'h08
`define MDL_MADJ_CYC       8'h13
`define MDL_DADJ_CYC       8'h0f
`define MDL_BEXT_CYC       8'h02
`define MDL_WEXT_CYC       8'h04
`define MDL_SH1_R          8'h02
`define MDL_SH1_M          8'h0f
`define MDL_SHN_R          8'h05
`define MDL_SHN_M          8'h11
`define MDL_LOG_RR         8'h03
`define MDL_LOG_RM         8'h0a
`define MDL_LOG_IR         8'h04
`define MDL_LOG_IM         8'h10
`define MDL_TSTI_M         8'h0a
`define MDL_ACC_B          8'h03
`define MDL_ACC_W          8'h04
`define MDL_ADJ_BASE       8'h0a
`endif

// ==== mdl_pkg.sv ====
/*
  types for the multiply/divide/logic decoder slice.
  assumes mdl_map.svh holds all numeric constants.
*/
package mdl_pkg;
  typedef enum logic [4:0] {
    MDL_OP_NONE, MDL_OP_SIGNED_MULTIPLY, MDL_OP_SIGNED_IMMEDIATE_MULTIPLY,
    MDL_OP_UNSIGNED_DIVIDE, MDL_OP_SIGNED_DIVIDE, MDL_OP_ASCII_MULTIPLY_ADJUST,
    MDL_OP_ASCII_DIVIDE_ADJUST, MDL_OP_BYTE_TO_WORD_EXTEND, MDL_OP_WORD_TO_DWORD_EXTEND,
    MDL_OP_ROTATE_LEFT, MDL_OP_ROTATE_RIGHT, MDL_OP_ROTATE_LEFT_THROUGH_CARRY,
    MDL_OP_ROTATE_RIGHT_THROUGH_CARRY, MDL_OP_SHIFT_LEFT, MDL_OP_LOGICAL_SHIFT_RIGHT,
    MDL_OP_ARITHMETIC_SHIFT_RIGHT, MDL_OP_AND, MDL_OP_OR, MDL_OP_TEST
  } mdl_op_e;

  typedef enum logic [1:0] {
    MDL_CNT_NONE, MDL_CNT_ONE, MDL_CNT_REG, MDL_CNT_IMM
  } mdl_cnt_e;

  typedef struct packed {
    mdl_op_e    op;
    logic       word;
    logic       mem;
    logic       reg_dest;
    logic       flags_only;
    logic [1:0] imm_bytes;
    mdl_cnt_e   cnt_src;
    logic [7:0] cyc_min;
    logic [7:0] cyc_max;
  } mdl_dec_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [7:0] count;
    logic       narrow_bus;
  } mdl_req_s;
endpackage : mdl_pkg

// ==== mdl_timer.sv ====
/*
  busy-cycle counter: holds the decoded operation for its cycle cost.
  assumes a load pulse only while idle.
*/
`timescale 1ns/1ps
module mdl_timer (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       load,
  input  wire logic [7:0] cycles,
  output logic            busy,
  output logic            done
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       done_r;
  logic       done_nxt;

  // ---------------------------------------------
  // count down
  // ---------------------------------------------
  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (load && cnt_r == 8'h00) begin
      cnt_nxt = cycles;
    end else if (cnt_r != 8'h00) begin
      cnt_nxt  = cnt_r - 8'h01;
      done_nxt = (cnt_r == 8'h01);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r  <= 8'h00;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = (cnt_r != 8'h00);
  assign done = done_r;

  property p_busy_len;
    @(posedge ref_clk) disable iff (sys_rst)
      (load && !busy && cycles == 8'h02) |=> busy ##1 busy ##1 !busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule : mdl_timer

// ==== mdl_decoder.sv ====
/*
  decoder and timing for multiply, divide, adjust, extend, shift/rotate
  and the and/test/or forms.
  assumes the prefetch queue presents one whole instruction (opcode,
  modrm, count/immediate byte) with a one-cycle valid; same clock.
*/
`timescale 1ns/1ps
`include "mdl_map.svh"
module mdl_decoder (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             req_valid,
  input  wire mdl_pkg::mdl_req_s req,
  input  wire logic [7:0]       count_register_low_byte,
  output logic                  req_ready,
  output mdl_pkg::mdl_dec_s     dec,
  output logic                  dec_valid,
  output logic                  dec_illegal,
  output logic                  exec_busy,
  output logic                  exec_done
);
  mdl_pkg::mdl_dec_s d_c;
  logic              legal_c;
  mdl_pkg::mdl_dec_s dec_r;
  mdl_pkg::mdl_dec_s dec_nxt;
  logic              val_r;
  logic              val_nxt;
  logic              ill_r;
  logic              ill_nxt;
  logic              take;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [7:0] wadd(input logic [7:0] c, input logic w, input logic m,
                                      input logic nb);
    wadd = (w && m && nb) ? c + `MDL_WORD_MEM_ADD : c;
  endfunction : wadd

  function automatic mdl_pkg::mdl_op_e shop(input logic [2:0] f);
    case (f)
      3'h0:    shop = mdl_pkg::MDL_OP_ROTATE_LEFT;
      3'h1:    shop = mdl_pkg::MDL_OP_ROTATE_RIGHT;
      3'h2:    shop = mdl_pkg::MDL_OP_ROTATE_LEFT_THROUGH_CARRY;
      3'h3:    shop = mdl_pkg::MDL_OP_ROTATE_RIGHT_THROUGH_CARRY;
      3'h4:    shop = mdl_pkg::MDL_OP_SHIFT_LEFT;
      3'h5:    shop = mdl_pkg::MDL_OP_LOGICAL_SHIFT_RIGHT;
      3'h7:    shop = mdl_pkg::MDL_OP_ARITHMETIC_SHIFT_RIGHT;
      default: shop = mdl_pkg::MDL_OP_NONE;
    endcase
  endfunction : shop

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  always_comb begin
    logic       w;
    logic       m;
    logic       nb;
    logic [2:0] rf;
    logic [7:0] op;
    logic [7:0] n;
    logic       st;
    w  = req.opcode[0];
    m  = (req.modrm[7:6] != 2'h3);
    nb = req.narrow_bus;
    rf = req.modrm[5:3];
    op = req.opcode;
    n  = 8'h00;
    st = 1'b0;
    legal_c = 1'b1;
    d_c = '0;
    d_c.word = w;
    d_c.mem  = m;
    if (op[7:1] == 7'b1111011) begin
      st = 1'b1;
      case (rf)
        3'h5: begin
          d_c.op      = mdl_pkg::MDL_OP_SIGNED_MULTIPLY;
          d_c.cyc_min = m ? (w ? `MDL_SMUL_MW : `MDL_SMUL_MB) : (w ? `MDL_SMUL_RW : `MDL_SMUL_RB);
          d_c.cyc_max = d_c.cyc_min + `MDL_SMUL_SPAN;
        end
        3'h6: begin
          d_c.op      = mdl_pkg::MDL_OP_UNSIGNED_DIVIDE;
          d_c.cyc_min = m ? (w ? `MDL_DIV_MW : `MDL_DIV_MB) : (w ? `MDL_DIV_RW : `MDL_DIV_RB);
          d_c.cyc_max = d_c.cyc_min;
        end
        3'h7: begin
          d_c.op      = mdl_pkg::MDL_OP_SIGNED_DIVIDE;
          d_c.cyc_min = m ? (w ? `MDL_SDIV_MW : `MDL_SDIV_MB) : (w ? `MDL_SDIV_RW : `MDL_SDIV_RB);
          d_c.cyc_max = d_c.cyc_min + `MDL_SDIV_SPAN;
        end
        3'h0: begin
          d_c.op         = mdl_pkg::MDL_OP_TEST;
          d_c.flags_only = 1'b1;
          d_c.imm_bytes  = w ? 2'h2 : 2'h1;
          d_c.cyc_min    = m ? `MDL_TSTI_M : `MDL_LOG_IR;
          d_c.cyc_max    = d_c.cyc_min;
        end
        default: legal_c = 1'b0;
      endcase
    end else if (op[7:2] == 6'b011010 && op[0]) begin
      d_c.op        = mdl_pkg::MDL_OP_SIGNED_IMMEDIATE_MULTIPLY;
      d_c.word      = 1'b1;
      d_c.reg_dest  = 1'b1;
      d_c.imm_bytes = op[1] ? 2'h1 : 2'h2;
      d_c.cyc_min   = m ? `MDL_IMMUL_M : `MDL_IMMUL_R;
      d_c.cyc_max   = d_c.cyc_min + `MDL_SMUL_SPAN;
    end else if ((op == 8'hd4 || op == 8'hd5) && req.modrm == `MDL_ADJ_BASE) begin
      d_c.word    = 1'b0;
      d_c.mem     = 1'b0;
      d_c.op      = op[0] ? mdl_pkg::MDL_OP_ASCII_DIVIDE_ADJUST
                          : mdl_pkg::MDL_OP_ASCII_MULTIPLY_ADJUST;
      d_c.cyc_min = op[0] ? `MDL_DADJ_CYC : `MDL_MADJ_CYC;
      d_c.cyc_max = d_c.cyc_min;
    end else if (op[7:1] == 7'b1001100) begin
      d_c.mem     = 1'b0;
      d_c.op      = op[0] ? mdl_pkg::MDL_OP_WORD_TO_DWORD_EXTEND
                          : mdl_pkg::MDL_OP_BYTE_TO_WORD_EXTEND;
      d_c.word    = op[0];
      d_c.cyc_min = op[0] ? `MDL_WEXT_CYC : `MDL_BEXT_CYC;
      d_c.cyc_max = d_c.cyc_min;
    end else if (op[7:1] == 7'b1101000) begin
      d_c.op      = shop(rf);
      d_c.cnt_src = mdl_pkg::MDL_CNT_ONE;
      d_c.cyc_min = m ? `MDL_SH1_M : `MDL_SH1_R;
      d_c.cyc_max = d_c.cyc_min;
      legal_c     = (rf != 3'h6);
    end else if (op[7:1] == 7'b1101001 || op[7:1] == 7'b1100000) begin
      d_c.op        = shop(rf);
      d_c.cnt_src   = op[4] ? mdl_pkg::MDL_CNT_REG : mdl_pkg::MDL_CNT_IMM;
      d_c.imm_bytes = op[4] ? 2'h0 : 2'h1;
      n             = op[4] ? count_register_low_byte : req.count;
      d_c.cyc_min   = (m ? `MDL_SHN_M : `MDL_SHN_R) + n;
      d_c.cyc_max   = d_c.cyc_min;
      legal_c       = (rf != 3'h6);
    end else if (op[7:2] == 6'b001000 || op[7:2] == 6'b000010) begin
      d_c.op       = op[5] ? mdl_pkg::MDL_OP_AND : mdl_pkg::MDL_OP_OR;
      d_c.reg_dest = op[1];
      st           = 1'b1;
      d_c.cyc_min  = m ? `MDL_LOG_RM : `MDL_LOG_RR;
      d_c.cyc_max  = d_c.cyc_min;
    end else if (op[7:1] == 7'b1000000 && (rf == 3'h4 || rf == 3'h1)) begin
      d_c.op        = rf[2] ? mdl_pkg::MDL_OP_AND : mdl_pkg::MDL_OP_OR;
      st            = 1'b1;
      d_c.imm_bytes = w ? 2'h2 : 2'h1;
      d_c.cyc_min   = m ? `MDL_LOG_IM : `MDL_LOG_IR;
      d_c.cyc_max   = d_c.cyc_min;
    end else if (op[7:1] == 7'b0010010 || op[7:1] == 7'b0000110 || op[7:1] == 7'b1010100) begin
      d_c.op         = (op[7:1] == 7'b1010100) ? mdl_pkg::MDL_OP_TEST
                     : (op[5] ? mdl_pkg::MDL_OP_AND : mdl_pkg::MDL_OP_OR);
      d_c.flags_only = (op[7:1] == 7'b1010100);
      d_c.mem        = 1'b0;
      d_c.imm_bytes  = w ? 2'h2 : 2'h1;
      d_c.cyc_min    = w ? `MDL_ACC_W : `MDL_ACC_B;
      d_c.cyc_max    = d_c.cyc_min;
    end else if (op[7:1] == 7'b1000010) begin
      st             = 1'b1;
      d_c.op         = mdl_pkg::MDL_OP_TEST;
      d_c.flags_only = 1'b1;
      d_c.cyc_min    = m ? `MDL_LOG_RM : `MDL_LOG_RR;
      d_c.cyc_max    = d_c.cyc_min;
    end else begin
      legal_c = 1'b0;
    end
    // starred forms only
    d_c.cyc_min = wadd(d_c.cyc_min, d_c.word, d_c.mem && st, nb);
    d_c.cyc_max = wadd(d_c.cyc_max, d_c.word, d_c.mem && st, nb);
    if (!legal_c) begin
      d_c = '0;
    end
  end

  // ---------------------------------------------
  // result register
  // ---------------------------------------------
  assign req_ready = !exec_busy;
  assign take      = req_valid && req_ready;

  always_comb begin
    dec_nxt = dec_r;
    val_nxt = 1'b0;
    ill_nxt = 1'b0;
    if (take) begin
      dec_nxt = d_c;
      val_nxt = legal_c;
      ill_nxt = !legal_c;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dec_r <= '0;
      val_r <= 1'b0;
      ill_r <= 1'b0;
    end else begin
      dec_r <= dec_nxt;
      val_r <= val_nxt;
      ill_r <= ill_nxt;
    end
  end

  assign dec         = dec_r;
  assign dec_valid   = val_r;
  assign dec_illegal = ill_r;

  mdl_timer u_timer (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .load    (take && legal_c),
    .cycles  (d_c.cyc_max),
    .busy    (exec_busy),
    .done    (exec_done)
  );

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  property p_div_reg_byte;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && req.opcode == 8'hf6 && req.modrm == 8'hf0) |=> dec.cyc_min == 8'h1d;
  endproperty
  a_div_reg_byte: assert property (p_div_reg_byte) else $error("divide timing wrong");

  property p_smul_span;
    @(posedge ref_clk) disable iff (sys_rst)
      (dec_valid && dec.op == mdl_pkg::MDL_OP_SIGNED_MULTIPLY)
        |-> dec.cyc_max == dec.cyc_min + 8'h03;
  endproperty
  a_smul_span: assert property (p_smul_span) else $error("multiply span wrong");

  property p_sdiv_span;
    @(posedge ref_clk) disable iff (sys_rst)
      (dec_valid && dec.op == mdl_pkg::MDL_OP_SIGNED_DIVIDE)
        |-> dec.cyc_max == dec.cyc_min + 8'h08;
  endproperty
  a_sdiv_span: assert property (p_sdiv_span) else $error("divide span wrong");

  property p_immul_imm;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && req.opcode == 8'h69) |=> dec.imm_bytes == 2'h2 && dec_valid;
  endproperty
  a_immul_imm: assert property (p_immul_imm) else $error("imm count wrong");

  property p_mul_adjust;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && req.opcode == 8'hd4 && req.modrm == 8'h0a)
        |=> dec.cyc_min == 8'h13 ##19 !exec_busy;
  endproperty
  a_mul_adjust: assert property (p_mul_adjust) else $error("adjust timing wrong");

  property p_div_adjust;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && req.opcode == 8'hd5 && req.modrm == 8'h0a) |=> dec.cyc_min == 8'h0f;
  endproperty
  a_div_adjust: assert property (p_div_adjust) else $error("adjust timing wrong");

  property p_byte_ext;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && req.opcode == 8'h98) |=> exec_busy ##1 exec_busy ##1 !exec_busy;
  endproperty
  a_byte_ext: assert property (p_byte_ext) else $error("extend timing wrong");

  property p_word_ext;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && req.opcode == 8'h99) |=> dec.cyc_min == 8'h04;
  endproperty
  a_word_ext: assert property (p_word_ext) else $error("extend timing wrong");

  property p_test_flags;
    @(posedge ref_clk) disable iff (sys_rst)
      (dec_valid && dec.op == mdl_pkg::MDL_OP_TEST) |-> dec.flags_only;
  endproperty
  a_test_flags: assert property (p_test_flags) else $error("test writes result");

  property p_narrow;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && req.narrow_bus && req.opcode == 8'h21 && req.modrm[7:6] == 2'h0)
        |=> dec.cyc_min == 8'h0e;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow bus add wrong");
endmodule : mdl_decoder

// ==== mdl_pq_model.sv ====
/*
  prefetch queue model: hands one whole instruction to the decoder.
  assumes the caller enters present at a falling clock edge.
*/
`timescale 1ns/1ps
module mdl_pq_model (
  input  wire logic         ref_clk,
  input  wire logic         req_ready,
  output logic              req_valid,
  output mdl_pkg::mdl_req_s req
);
  // ----------------------------------------
  // presentation
  // ----------------------------------------
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // rude set: presents without waiting for ready; always lets one edge pass first
  task automatic present(input mdl_pkg::mdl_req_s r, input bit rude);
    do @(negedge ref_clk); while (!rude && req_ready !== 1'b1);
    req       = r;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    req       = ~r;
  endtask : present
endmodule : mdl_pq_model

// ==== testbench.sv ====
/*
  self-checking bench for mdl_decoder: corner and random instructions.
  assumes mdl_pkg and mdl_pq_model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic              ref_clk;
  logic              sys_rst;
  logic [7:0]        cnt_low;
  logic              req_valid;
  mdl_pkg::mdl_req_s req;
  logic              req_ready;
  mdl_pkg::mdl_dec_s dec;
  logic              dec_valid;
  logic              dec_illegal;
  logic              exec_busy;
  logic              exec_done;
  int                error_cnt;
  int                cmp_count;
  logic [7:0]        ops [32] = '{8'hf6, 8'hf7, 8'h69, 8'h6b, 8'hd4, 8'hd5, 8'h98, 8'h99,
    8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hc0, 8'hc1, 8'h20, 8'h21, 8'h22, 8'h23, 8'h08, 8'h09,
    8'h0a, 8'h0b, 8'h80, 8'h81, 8'h24, 8'h25, 8'h0c, 8'h0d, 8'ha8, 8'ha9, 8'h84, 8'h85};

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  mdl_pq_model pq (.ref_clk(ref_clk), .req_ready(req_ready), .req_valid(req_valid), .req(req));

  mdl_decoder dut (
    .ref_clk                 (ref_clk),
    .sys_rst                 (sys_rst),
    .req_valid               (req_valid),
    .req                     (req),
    .count_register_low_byte (cnt_low),
    .req_ready               (req_ready),
    .dec                     (dec),
    .dec_valid               (dec_valid),
    .dec_illegal             (dec_illegal),
    .exec_busy               (exec_busy),
    .exec_done               (exec_done)
  );

  // ----------------------------------------
  // expectation and checking
  // ----------------------------------------
  task automatic conclude;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic void mk(inout mdl_pkg::mdl_dec_s e, input mdl_pkg::mdl_op_e o,
                             input logic [7:0] b, input logic [7:0] s);
    e.op      = o;
    e.cyc_min = b;
    e.cyc_max = b + s;
  endfunction : mk

  function automatic mdl_pkg::mdl_req_s rq(input logic [7:0] o, input logic [7:0] m,
                                           input logic [7:0] c, input logic nb);
    return {o, m, c, nb};
  endfunction : rq

  // k: bit0 modrm fields, bit1 direction bit, bit2 shift count source
  function automatic void expect_dec(input mdl_pkg::mdl_req_s r, input logic [7:0] cl_v,
                                     output mdl_pkg::mdl_dec_s e, output bit ill,
                                     output bit [2:0] k);
    logic [2:0] f;
    logic       w;
    logic       m;
    logic       st;
    logic [7:0] c;
    logic [7:0] n;
    f = r.modrm[5:3];
    w = r.opcode[0];
    m = r.modrm[7:6] != 2'b11;
    n = r.opcode[1] ? cl_v : r.count;
    e = '0;
    e.word = w;
    e.mem = m;
    ill = 1'b0;
    k = 3'b001;
    st = 1'b0;
    casez (r.opcode)
      8'b1111011?: begin
        st = 1'b1;
        e.flags_only = f == 3'd0;
        e.imm_bytes = (f == 3'd0) ? (w ? 2'h2 : 2'h1) : 2'h0;
        case (f)
          3'd0: mk(e, mdl_pkg::MDL_OP_TEST, m ? 8'h0a : 8'h04, 8'h00);
          3'd5: begin
            c = m ? (w ? 8'h28 : 8'h1f) : (w ? 8'h22 : 8'h19);
            mk(e, mdl_pkg::MDL_OP_SIGNED_MULTIPLY, c, 8'h03);
          end
          3'd6: begin
            c = m ? (w ? 8'h2c : 8'h23) : (w ? 8'h26 : 8'h1d);
            mk(e, mdl_pkg::MDL_OP_UNSIGNED_DIVIDE, c, 8'h00);
          end
          3'd7: begin
            c = m ? (w ? 8'h3b : 8'h32) : (w ? 8'h35 : 8'h2c);
            mk(e, mdl_pkg::MDL_OP_SIGNED_DIVIDE, c, 8'h08);
          end
          default: ill = 1'b1;
        endcase
      end
      8'b011010?1: begin
        mk(e, mdl_pkg::MDL_OP_SIGNED_IMMEDIATE_MULTIPLY, m ? 8'h1d : 8'h16, 8'h03);
        e.word = 1'b1;
        e.reg_dest = 1'b1;
        e.imm_bytes = r.opcode[1] ? 2'h1 : 2'h2;
      end
      8'hd4: mk(e, mdl_pkg::MDL_OP_ASCII_MULTIPLY_ADJUST, 8'h13, 8'h00);
      8'hd5: mk(e, mdl_pkg::MDL_OP_ASCII_DIVIDE_ADJUST, 8'h0f, 8'h00);
      8'h98: mk(e, mdl_pkg::MDL_OP_BYTE_TO_WORD_EXTEND, 8'h02, 8'h00);
      8'h99: mk(e, mdl_pkg::MDL_OP_WORD_TO_DWORD_EXTEND, 8'h04, 8'h00);
      8'b110100??, 8'b1100000?: begin
        k = 3'b101;
        e.imm_bytes = {1'b0, !r.opcode[4]};
        ill = f == 3'd6;
        e.cnt_src = !r.opcode[4] ? mdl_pkg::MDL_CNT_IMM :
                    r.opcode[1] ? mdl_pkg::MDL_CNT_REG : mdl_pkg::MDL_CNT_ONE;
        c = (r.opcode[4] && !r.opcode[1]) ? (m ? 8'h0f : 8'h02) : (m ? 8'h11 : 8'h05) + n;
        mk(e, mdl_pkg::mdl_op_e'(f == 3'd7 ? 5'h0f : 5'h09 + 5'(f)), c, 8'h00);
      end
      8'b001000??, 8'b000010??: begin
        mk(e, r.opcode[5] ? mdl_pkg::MDL_OP_AND : mdl_pkg::MDL_OP_OR, m ? 8'h0a : 8'h03, 8'h00);
        e.reg_dest = r.opcode[1];
        k = 3'b011;
        st = 1'b1;
      end
      8'b1000000?: begin
        mk(e, f == 3'd4 ? mdl_pkg::MDL_OP_AND : mdl_pkg::MDL_OP_OR, m ? 8'h10 : 8'h04, 8'h00);
        ill = !(f inside {3'd1, 3'd4});
        st = 1'b1;
      end
      8'b0010010?, 8'b0000110?:
        mk(e, r.opcode[5] ? mdl_pkg::MDL_OP_AND : mdl_pkg::MDL_OP_OR, w ? 8'h04 : 8'h03, 8'h00);
      8'b1010100?: begin
        mk(e, mdl_pkg::MDL_OP_TEST, w ? 8'h04 : 8'h03, 8'h00);
        e.flags_only = 1'b1;
      end
      8'b1000010?: begin
        mk(e, mdl_pkg::MDL_OP_TEST, m ? 8'h0a : 8'h03, 8'h00);
        e.flags_only = 1'b1;
        st = 1'b1;
      end
      default: ill = 1'b1;
    endcase
    if (r.opcode inside {8'hd4, 8'hd5, 8'h98, 8'h99, 8'h24, 8'h25, 8'h0c, 8'h0d, 8'ha8, 8'ha9})
      k = 3'b000;
    if (r.opcode inside {8'h80, 8'h81, 8'h24, 8'h25, 8'h0c, 8'h0d, 8'ha8, 8'ha9})
      e.imm_bytes = w ? 2'h2 : 2'h1;
    if (st && w && m && r.narrow_bus) begin
      e.cyc_min += 8'h04;
      e.cyc_max += 8'h04;
    end
  endfunction : expect_dec

  // mode 0 plain, 1 refused request mid-run, 2 reset mid-run
  task automatic run(input mdl_pkg::mdl_req_s r, input int mode);
    mdl_pkg::mdl_dec_s e;
    bit                ill;
    bit [2:0]          k;
    int                n;
    expect_dec(r, cnt_low, e, ill, k);
    pq.present(r, 1'b0);
    chk({dec_valid, dec_illegal}, {!ill, ill});
    if (!ill) begin
      chk(dec.op, e.op);
      chk({dec.cyc_min, dec.cyc_max}, {e.cyc_min, e.cyc_max});
      chk(dec.flags_only, e.flags_only);
      if (k[0]) chk({dec.word, dec.mem}, {e.word, e.mem});
      if (k[1]) chk(dec.reg_dest, e.reg_dest);
      if (k[2]) chk(dec.cnt_src, e.cnt_src);
      chk({dec.reg_dest, dec.imm_bytes}, {e.reg_dest, e.imm_bytes});
    end
    n = 0;
    if (mode == 1) begin
      pq.present(~r, 1'b1);
      chk({dec_valid, dec_illegal, dec.op}, {2'b00, e.op});
      n = 2;
    end
    if (mode == 2) begin
      sys_rst = 1'b1;
      @(negedge ref_clk);
      sys_rst = 1'b0;
      chk(dec, 0);
      chk({dec_valid, dec_illegal, exec_busy, exec_done, req_ready}, 1);
      return;
    end
    while (exec_busy === 1'b1 && n < 300) begin
      chk(req_ready, 1'b0);
      n++;
      @(negedge ref_clk);
    end
    chk(n, ill ? 0 : e.cyc_max);
    chk({exec_done, req_ready}, {!ill, 1'b1});
  endtask : run

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    mdl_pkg::mdl_req_s r;
    void'($urandom(32'hcae61057));
    error_cnt = 0;
    cmp_count = 0;
    cnt_low = 8'h00;
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk({req_ready, dec_valid, exec_busy}, 3'b100);
    run(rq(8'hd2, 8'hc0, 8'h00, 1'b0), 0);
    run(rq(8'hc1, 8'h07, 8'hc8, 1'b0), 0);
    run(rq(8'hf7, 8'h38, 8'h00, 1'b1), 1);
    run(rq(8'hf6, 8'hc8, 8'h00, 1'b0), 0);
    run(rq(8'h21, 8'h05, 8'h00, 1'b1), 0);
    run(rq(8'h98, 8'hc0, 8'h00, 1'b0), 0);
    run(rq(8'h99, 8'hc0, 8'h00, 1'b0), 0);
    run(rq(8'hd4, 8'h0a, 8'h00, 1'b0), 0);
    run(rq(8'hd5, 8'h0a, 8'h00, 1'b0), 0);
    run(rq(8'h6b, 8'h00, 8'h12, 1'b0), 0);
    run(rq(8'hf7, 8'he8, 8'h00, 1'b0), 2);
    run(rq(8'h69, 8'hc0, 8'h34, 1'b0), 0);
    for (int i = 0; i < 8; i++) run(rq(8'hd1, {2'b11, 3'(i), 3'b000}, 8'h00, 1'b0), 0);
    for (int i = 0; i < 16; i++) begin
      run(rq({7'b1111011, 1'(i / 8)}, {2'b11, 3'(i), 3'b000}, 8'h00, 1'b0), 0);
    end
    repeat (150) begin
      r = rq(ops[$urandom_range(0, 31)], 8'($urandom), 8'($urandom_range(0, 200)), 1'($urandom));
      if (r.opcode inside {8'hd4, 8'hd5}) r.modrm = 8'h0a;
      if (r.opcode inside {8'h80, 8'h81}) r.modrm[5:3] = $urandom_range(0, 1) ? 3'd4 : 3'd1;
      if (r.opcode inside {8'h98, 8'h99, 8'h24, 8'h25, 8'h0c, 8'h0d, 8'ha8, 8'ha9})
        r.modrm[7:6] = 2'b11;
      cnt_low = 8'($urandom_range(0, 200));
      run(r, 0);
    end
    conclude();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    $display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
    conclude();
  end
endmodule : testbench
